/* hw/cps_pkg.sv */
package cps_pkg;
  // Binary command codes
  localparam logic [7:0] CMD_SLEEP_SEL = 8'h01;
  localparam logic [7:0] CMD_IDLE_TIME = 8'h02;
  localparam logic [7:0] CMD_LINE_FUNC = 8'h16;
  localparam logic [7:0] CMD_SIG_LEVEL = 8'h1C;
  localparam logic [7:0] CMD_SN_UPPER = 8'h25;
  localparam logic [7:0] CMD_SN_LOWER = 8'h26;
  localparam logic [7:0] CMD_STOP_BITS = 8'h36;

  // Reset values
  localparam logic [7:0] SLEEP_SEL_RST = 8'h00;
  localparam logic [15:0] IDLE_TIME_RST = 16'h0064;
  localparam logic [7:0] LINE_FUNC_RST = 8'h00;
  localparam logic [7:0] STOP_BITS_RST = 8'h00;
  localparam logic [7:0] SIG_LEVEL_RST = 8'h06;

  // Legal ranges and encodings
  localparam logic [7:0] SIG_LEVEL_MIN = 8'h06;
  localparam logic [7:0] SIG_LEVEL_MAX = 8'h36;
  localparam logic [15:0] IDLE_TIME_MIN = 16'h0010;
  localparam logic [7:0] LINE_UNUSED = 8'h00;
  localparam logic [7:0] LINE_BINARY = 8'h01;
  localparam logic [7:0] LINE_RTS = 8'h02;
  localparam logic [7:0] STOP_ONE = 8'h00;
  localparam logic [7:0] STOP_TWO = 8'h01;
  localparam logic [7:0] SLEEP_OFF = 8'h00;
  localparam logic [7:0] SLEEP_PIN = 8'h01;
  localparam logic [7:0] SLEEP_CYC_MIN = 8'h03;
  localparam logic [7:0] SLEEP_CYC_MAX = 8'h08;

  // Timing: 100 ms base tick at 50 MHz
  localparam int CLK_KHZ = 50_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int CYC_BASE_MS = 500;
  localparam logic [7:0] CYC_BASE_TICKS = 8'(CYC_BASE_MS / TICK_MS);
  localparam logic [7:0] LISTEN_TICKS_DEF = 8'h01;

  // Serial number, arbitrary value
  localparam logic [31:0] SERIAL_NUMBER_DEF = 32'h0000_1234;

  typedef enum logic [1:0] {
    S_ACTIVE,
    S_ASLEEP,
    S_LISTEN,
    S_INIT_WAIT
  } cps_sleep_t;
endpackage

/* hw/cps_tick_gen.sv */
`timescale 1ns/10ps
module cps_tick_gen #(
  parameter int DIV = 5_000_000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Tick
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

/* hw/cps_param_bank.sv */
// Summary of operation
// (R1) Signal level reads one byte, clamped 0x06..0x36, larger is stronger.
// (R2) Line function: 0 unused, 1 binary programming, 2 RTS flow control.
// (R3) Stop bits: 0 gives one stop bit, 1 gives two; default 0.
// (R4) Serial number upper word read-only under code 0x25, two bytes.
// (R5) Serial number lower word read-only under code 0x26, two bytes.
// (R6) Sleep select accepts 0, 1, 3 to 8; value 2 is illegal.
// (R7) Cyclic settings 3..8 wake after 0.5 s doubling up to 16 s.
// (R8) Sleep select 0 keeps the device always active.
// (R9) Cyclic wake: initializer seen means receive after it ends, else sleep again.
// (R10) Idle time counts 100 ms units, range 0x10..0xFFFF, default 0x64.
// (R11) Inactivity is no transmit and no receive; sleep once idle time elapses.
// (R12) Idle timer acts only when cyclic sleep is selected.
// (R13) Command codes 0x1C, 0x01, 0x02, 0x16, 0x36 address the parameters.
// (R14) One byte returned for byte parameters, two for serial words and idle time.
// (R15) Host also programs idle and initializer timing when choosing cyclic sleep; the cps_host cyclic task writes only idle time and sleep select.
// (R16) Out-of-range writes are rejected and leave the parameter unchanged.
`timescale 1ns/10ps
module cps_param_bank
  import cps_pkg::*;
#(
  parameter int TICK_CYCLES_P = cps_pkg::TICK_CYCLES,
  parameter logic [31:0] SERIAL_NUMBER = cps_pkg::SERIAL_NUMBER_DEF,
  parameter logic [7:0] LISTEN_TICKS = cps_pkg::LISTEN_TICKS_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Binary command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  output logic rsp_valid,
  output logic rsp_error,
  output logic rsp_two_bytes,
  output logic [15:0] rsp_data,
  // Radio status
  input wire logic pkt_rx_done,
  input wire logic [7:0] pkt_signal_level,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic wake_init_seen,
  // Pins
  input wire logic multipurpose_input_line,
  input wire logic sleep_pin,
  // Configuration outputs
  output logic binary_prog_en,
  output logic rts_hold,
  output logic two_stop_bits,
  output logic low_power,
  output logic rx_sync_start
);
  import cps_pkg::*;

  logic [7:0] sleep_select_r;
  logic [15:0] idle_time_before_sleep_r;
  logic [7:0] line_function_select_r;
  logic [7:0] received_signal_level_r;
  logic [7:0] stop_bit_count_r;
  logic line_s1_r, line_s2_r, pin_s1_r, pin_s2_r;
  logic code_known, two_byte, wr_legal, wr_ok;
  logic [15:0] rd_data;
  logic cyclic, tick, idle, per_done;
  logic [7:0] period_ticks;
  logic [15:0] idle_cnt_r;
  logic [7:0] per_cnt_r;
  cps_sleep_t state_r, state_nxt;

  // Pin synchronisers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      line_s1_r <= 1'b0;
      line_s2_r <= 1'b0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      line_s1_r <= multipurpose_input_line;
      line_s2_r <= line_s1_r;
      pin_s1_r <= sleep_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // (R13) code decode
  always_comb
  begin
    code_known = 1'b1;
    two_byte = 1'b0;
    wr_legal = 1'b0;
    rd_data = 16'h0000;
    unique case (cmd_code)
      CMD_SLEEP_SEL:
      begin
        rd_data = {8'h00, sleep_select_r};
        // (R6) legal sleep values
        wr_legal = (cmd_data[15:8] == 8'h00) && ((cmd_data[7:0] == SLEEP_OFF)
          || (cmd_data[7:0] == SLEEP_PIN) || ((cmd_data[7:0] >= SLEEP_CYC_MIN)
          && (cmd_data[7:0] <= SLEEP_CYC_MAX)));
      end
      CMD_IDLE_TIME:
      begin
        rd_data = idle_time_before_sleep_r;
        two_byte = 1'b1;
        // (R10) idle time lower bound
        wr_legal = (cmd_data >= IDLE_TIME_MIN);
      end
      CMD_LINE_FUNC:
      begin
        rd_data = {8'h00, line_function_select_r};
        wr_legal = (cmd_data <= {8'h00, LINE_RTS});
      end
      CMD_SIG_LEVEL:
        rd_data = {8'h00, received_signal_level_r};
      // (R4) upper serial word
      CMD_SN_UPPER:
      begin
        rd_data = SERIAL_NUMBER[31:16];
        two_byte = 1'b1;
      end
      // (R5) lower serial word
      CMD_SN_LOWER:
      begin
        rd_data = SERIAL_NUMBER[15:0];
        two_byte = 1'b1;
      end
      CMD_STOP_BITS:
      begin
        rd_data = {8'h00, stop_bit_count_r};
        wr_legal = (cmd_data <= {8'h00, STOP_TWO});
      end
      default:
        code_known = 1'b0;
    endcase
  end

  assign wr_ok = cmd_valid && cmd_write && wr_legal;

  // (R16) writable parameters, legal writes only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_select_r <= SLEEP_SEL_RST;
      idle_time_before_sleep_r <= IDLE_TIME_RST;
      line_function_select_r <= LINE_FUNC_RST;
      stop_bit_count_r <= STOP_BITS_RST;
    end
    else if (wr_ok)
    begin
      if (cmd_code == CMD_SLEEP_SEL)
        sleep_select_r <= cmd_data[7:0];
      if (cmd_code == CMD_IDLE_TIME)
        idle_time_before_sleep_r <= cmd_data;
      if (cmd_code == CMD_LINE_FUNC)
        line_function_select_r <= cmd_data[7:0];
      if (cmd_code == CMD_STOP_BITS)
        stop_bit_count_r <= cmd_data[7:0];
    end
  end

  // (R1) signal level clamp
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      received_signal_level_r <= SIG_LEVEL_RST;
    else if (pkt_rx_done)
    begin
      if (pkt_signal_level < SIG_LEVEL_MIN)
        received_signal_level_r <= SIG_LEVEL_MIN;
      else if (pkt_signal_level > SIG_LEVEL_MAX)
        received_signal_level_r <= SIG_LEVEL_MAX;
      else
        received_signal_level_r <= pkt_signal_level;
    end
  end

  // (R14) answer with byte count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_two_bytes <= 1'b0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      rsp_valid <= cmd_valid;
      rsp_error <= cmd_valid && (!code_known || (cmd_write && !wr_legal));
      rsp_two_bytes <= cmd_valid && two_byte;
      if (cmd_valid)
        rsp_data <= wr_ok ? (two_byte ? cmd_data : {8'h00, cmd_data[7:0]}) : rd_data;
    end
  end

  // (R2) line function and (R3) stop bits
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      binary_prog_en <= 1'b0;
      rts_hold <= 1'b0;
      two_stop_bits <= 1'b0;
    end
    else
    begin
      binary_prog_en <= (line_function_select_r == LINE_BINARY) && line_s2_r;
      rts_hold <= (line_function_select_r == LINE_RTS) && line_s2_r;
      two_stop_bits <= (stop_bit_count_r == STOP_TWO);
    end
  end

  cps_tick_gen #(
    .DIV(TICK_CYCLES_P)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  assign cyclic = (sleep_select_r >= SLEEP_CYC_MIN) && (sleep_select_r <= SLEEP_CYC_MAX);
  // (R11) inactivity definition
  assign idle = !tx_active && !rx_active;
  // (R7) period doubles per step
  assign period_ticks = 8'(CYC_BASE_TICKS << (sleep_select_r - SLEEP_CYC_MIN));
  assign per_done = tick && ((per_cnt_r + 8'h01) >= (state_r == S_LISTEN ? LISTEN_TICKS
    : period_ticks));

  // (R12) cyclic sleep state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_ACTIVE:
        if (cyclic && idle && tick && ((idle_cnt_r + 16'h0001) >= idle_time_before_sleep_r))
          state_nxt = S_ASLEEP;
      S_ASLEEP:
        if (!cyclic)
          state_nxt = S_ACTIVE;
        else if (per_done)
          state_nxt = S_LISTEN;
      // (R9) listen window
      S_LISTEN:
        if (!cyclic)
          state_nxt = S_ACTIVE;
        else if (wake_init_seen)
          state_nxt = S_INIT_WAIT;
        else if (per_done)
          state_nxt = S_ASLEEP;
      S_INIT_WAIT:
        if (!wake_init_seen || !cyclic)
          state_nxt = S_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_r <= S_ACTIVE;
    else
      state_r <= state_nxt;
  end

  // (R11) idle and period counters
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_cnt_r <= 16'h0000;
      per_cnt_r <= 8'h00;
    end
    else
    begin
      if (state_r != S_ACTIVE || !cyclic || !idle)
        idle_cnt_r <= 16'h0000;
      else if (tick && idle_cnt_r != 16'hFFFF)
        idle_cnt_r <= idle_cnt_r + 16'h0001;
      // A new sleep setting restarts the period so a shorter one cannot be overrun
      if (state_nxt != state_r || (wr_ok && cmd_code == CMD_SLEEP_SEL))
        per_cnt_r <= 8'h00;
      else if (tick)
        per_cnt_r <= per_cnt_r + 8'h01;
    end
  end

  // (R8) low power output
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      low_power <= 1'b0;
      rx_sync_start <= 1'b0;
    end
    else
    begin
      if (sleep_select_r == SLEEP_PIN)
        low_power <= pin_s2_r;
      else
        low_power <= cyclic && (state_nxt == S_ASLEEP);
      rx_sync_start <= (state_r == S_INIT_WAIT) && !wake_init_seen && cyclic;
    end
  end

  AST_SIG_RANGE: assert property (@(posedge core_clk) disable iff (rst) // (R1)
    received_signal_level_r >= SIG_LEVEL_MIN && received_signal_level_r <= SIG_LEVEL_MAX)
    else $error("signal level out of range");
  AST_RTS_SEL: assert property (@(posedge core_clk) disable iff (rst) // (R2)
    rts_hold |-> $past(line_function_select_r) == LINE_RTS)
    else $error("rts hold without rts mode");
  AST_STOP_TWO: assert property (@(posedge core_clk) disable iff (rst) // (R3)
    (cmd_valid && cmd_write && cmd_code == CMD_STOP_BITS && cmd_data == 16'h0001)
    |=> ##1 two_stop_bits)
    else $error("two stop bits not applied");
  AST_SN_UPPER: assert property (@(posedge core_clk) disable iff (rst) // (R4)
    (cmd_valid && !cmd_write && cmd_code == CMD_SN_UPPER)
    |=> rsp_valid && rsp_two_bytes && !rsp_error && rsp_data == SERIAL_NUMBER[31:16])
    else $error("bad upper serial answer");
  AST_SN_LOWER: assert property (@(posedge core_clk) disable iff (rst) // (R5)
    (cmd_valid && !cmd_write && cmd_code == CMD_SN_LOWER)
    |=> rsp_valid && rsp_two_bytes && rsp_data == SERIAL_NUMBER[15:0])
    else $error("bad lower serial answer");
  AST_SLEEP_LEGAL: assert property (@(posedge core_clk) disable iff (rst) // (R6)
    sleep_select_r != 8'h02 && sleep_select_r <= SLEEP_CYC_MAX)
    else $error("illegal sleep select stored");
  AST_PERIOD: assert property (@(posedge core_clk) disable iff (rst) // (R7)
    (state_r == S_ASLEEP && cyclic) |-> per_cnt_r < period_ticks)
    else $error("sleep period overrun");
  AST_NO_SLEEP: assert property (@(posedge core_clk) disable iff (rst) // (R8)
    (sleep_select_r == SLEEP_OFF) [*2] |-> !low_power)
    else $error("low power with sleep disabled");
  AST_RX_START: assert property (@(posedge core_clk) disable iff (rst) // (R9)
    rx_sync_start |-> $past(state_r) == S_INIT_WAIT && state_r == S_ACTIVE)
    else $error("receive start outside initializer end");
  AST_IDLE_MIN: assert property (@(posedge core_clk) disable iff (rst) // (R10)
    idle_time_before_sleep_r >= IDLE_TIME_MIN)
    else $error("idle time below minimum");
  AST_BUSY_CLR: assert property (@(posedge core_clk) disable iff (rst) // (R11)
    !idle |=> idle_cnt_r == 16'h0000)
    else $error("idle count runs while busy");
  AST_CYC_ONLY: assert property (@(posedge core_clk) disable iff (rst) // (R12)
    state_r != S_ACTIVE |-> $past(cyclic))
    else $error("sleep state without cyclic mode");
  AST_REJECT: assert property (@(posedge core_clk) disable iff (rst) // (R16)
    (cmd_valid && cmd_write && cmd_code == CMD_SLEEP_SEL && cmd_data == 16'h0002)
    |=> $stable(sleep_select_r) && rsp_error)
    else $error("illegal sleep write accepted");
endmodule

/* test/cps_host.sv */
`timescale 1ns/10ps
module cps_host
  import cps_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Command request
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_data,
  // Answer
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic rsp_two_bytes,
  input wire logic [15:0] rsp_data
);
  logic [18:0] last_rsp;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 16'h0000;
    last_rsp = '0;
  end
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_data <= data;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    // Released lines do not keep their last value
    cmd_write <= ~wr;
    cmd_code <= ~code;
    cmd_data <= ~data;
    #1;
    last_rsp = {rsp_valid, rsp_error, rsp_two_bytes, rsp_data};
  endtask
  // idle time set with cyclic mode
  task automatic cyclic(input logic [7:0] sel, input logic [15:0] idle);
    access(1'b1, CMD_IDLE_TIME, idle);
    access(1'b1, CMD_SLEEP_SEL, sel);
  endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import cps_pkg::*;
  // Arbitrary serial number
  localparam logic [31:0] SN = 32'hC3A5_5A3C;
  logic core_clk, rst, cmd_valid, cmd_write, rsp_valid, rsp_error, rsp_two_bytes;
  logic [7:0] cmd_code, pkt_signal_level;
  logic [15:0] cmd_data, rsp_data;
  logic pkt_rx_done, tx_active, rx_active, wake_init_seen, multipurpose_input_line, sleep_pin;
  logic binary_prog_en, rts_hold, two_stop_bits, low_power, rx_sync_start;
  int n_errors = 0;
  int n_compared = 0;
  int n, k;
  cps_host i_cps_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_two_bytes(rsp_two_bytes), .rsp_data(rsp_data));
  cps_param_bank #(.TICK_CYCLES_P(4), .SERIAL_NUMBER(SN), .LISTEN_TICKS(8'h01))
  i_cps_param_bank (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_two_bytes(rsp_two_bytes), .rsp_data(rsp_data),
    .pkt_rx_done(pkt_rx_done), .pkt_signal_level(pkt_signal_level), .tx_active(tx_active),
    .rx_active(rx_active), .wake_init_seen(wake_init_seen),
    .multipurpose_input_line(multipurpose_input_line), .sleep_pin(sleep_pin),
    .binary_prog_en(binary_prog_en), .rts_hold(rts_hold), .two_stop_bits(two_stop_bits),
    .low_power(low_power), .rx_sync_start(rx_sync_start));
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] data,
    input logic err, input logic two, input logic [15:0] exp);
    i_cps_host.access(wr, code, data);
    if (err)
      `CHK(i_cps_host.last_rsp[18:17], 2'b11)
    else
      `CHK(i_cps_host.last_rsp, {2'b10, two, exp})
  endtask
  task automatic params(input logic [7:0] sel, input logic [15:0] idle, input logic [7:0] lf,
    input logic [7:0] sb);
    acc(1'b0, CMD_SLEEP_SEL, 16'h0000, 1'b0, 1'b0, {8'h00, sel});
    acc(1'b0, CMD_IDLE_TIME, 16'h0000, 1'b0, 1'b1, idle);
    acc(1'b0, CMD_LINE_FUNC, 16'h0000, 1'b0, 1'b0, {8'h00, lf});
    acc(1'b0, CMD_STOP_BITS, 16'h0000, 1'b0, 1'b0, {8'h00, sb});
  endtask
  task automatic wait_lp(input logic v, input int bound, output int cnt);
    cnt = 0;
    while (low_power !== v)
    begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (cnt > bound)
      begin
        n_errors++;
        $display("unexpected at %0t got %h exp %h", $time, low_power, v);
        final_report();
      end
    end
  endtask
  task automatic level(input logic [7:0] lvl, input logic [7:0] exp);
    @(posedge core_clk);
    pkt_rx_done <= 1'b1;
    pkt_signal_level <= lvl;
    @(posedge core_clk);
    pkt_rx_done <= 1'b0;
    acc(1'b0, CMD_SIG_LEVEL, 16'h0000, 1'b0, 1'b0, {8'h00, exp});
  endtask
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial
  begin
    rst = 1'b1;
    pkt_rx_done = 1'b0;
    pkt_signal_level = 8'h00;
    tx_active = 1'b0;
    rx_active = 1'b0;
    wake_init_seen = 1'b0;
    multipurpose_input_line = 1'b0;
    sleep_pin = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    params(8'h00, 16'h0064, 8'h00, 8'h00);
    acc(1'b0, CMD_SIG_LEVEL, 16'h0000, 1'b0, 1'b0, 16'h0006);
    acc(1'b0, CMD_SN_UPPER, 16'h0000, 1'b0, 1'b1, SN[31:16]);
    acc(1'b0, CMD_SN_LOWER, 16'h0000, 1'b0, 1'b1, SN[15:0]);
    acc(1'b1, CMD_SLEEP_SEL, 16'h0002, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_SLEEP_SEL, 16'h0009, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_SLEEP_SEL, 16'h0103, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_IDLE_TIME, 16'h000F, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_LINE_FUNC, 16'h0003, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_STOP_BITS, 16'h0002, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_SIG_LEVEL, 16'h0020, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_SN_UPPER, 16'h0001, 1'b1, 1'b0, 16'h0000);
    acc(1'b1, CMD_SN_LOWER, 16'h0001, 1'b1, 1'b0, 16'h0000);
    acc(1'b0, 8'h99, 16'h0000, 1'b1, 1'b0, 16'h0000);
    params(8'h00, 16'h0064, 8'h00, 8'h00);
    acc(1'b1, CMD_IDLE_TIME, 16'hFFFF, 1'b0, 1'b1, 16'hFFFF);
    acc(1'b1, CMD_STOP_BITS, 16'h0001, 1'b0, 1'b0, 16'h0001);
    multipurpose_input_line <= 1'b1;
    acc(1'b1, CMD_LINE_FUNC, 16'h0001, 1'b0, 1'b0, 16'h0001);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK({binary_prog_en, rts_hold, two_stop_bits}, 3'b101)
    acc(1'b1, CMD_STOP_BITS, 16'h0000, 1'b0, 1'b0, 16'h0000);
    acc(1'b1, CMD_LINE_FUNC, 16'h0002, 1'b0, 1'b0, 16'h0002);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK({binary_prog_en, rts_hold, two_stop_bits}, 3'b010)
    params(8'h00, 16'hFFFF, 8'h02, 8'h00);
    level(8'h20, 8'h20);
    level(8'h02, 8'h06);
    level(8'h40, 8'h36);
    acc(1'b1, CMD_SLEEP_SEL, 16'h0001, 1'b0, 1'b0, 16'h0001);
    sleep_pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(low_power, 1'b1)
    i_cps_host.access(1'b1, CMD_SLEEP_SEL, 16'h0000);
    i_cps_host.access(1'b1, CMD_IDLE_TIME, 16'h0010);
    repeat (200) @(posedge core_clk);
    #1;
    `CHK(low_power, 1'b0)
    sleep_pin <= 1'b0;
    tx_active <= 1'b1;
    i_cps_host.cyclic(8'h03, 16'h0010);
    repeat (150) @(posedge core_clk);
    #1;
    `CHK(low_power, 1'b0)
    tx_active <= 1'b0;
    rx_active <= 1'b1;
    repeat (150) @(posedge core_clk);
    #1;
    `CHK(low_power, 1'b0)
    rx_active <= 1'b0;
    for (k = 0; k < 6; k++)
    begin
      i_cps_host.access(1'b1, CMD_SLEEP_SEL, 16'h0000);
      i_cps_host.cyclic(8'(3 + k), 16'h0010);
      wait_lp(1'b1, 200, n);
      wait_lp(1'b0, (20 << k) + 8, n);
      `CHK(n >= (20 << k) - 5 && n <= (20 << k) + 5, 1'b1)
      wait_lp(1'b1, 12, n);
    end
    wait_lp(1'b0, (20 << 5) + 8, n);
    wake_init_seen <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    `CHK(low_power, 1'b0)
    wake_init_seen <= 1'b0;
    n = 0;
    while (rx_sync_start !== 1'b1 && n < 5)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(rx_sync_start, 1'b1)
    final_report();
  end
endmodule
